// file: tb/deac_cpu_model.sv
/*
 * Cpu data bus model: issues one-cycle write and read strobes.
 * Assumes the controller answers a read in the cycle after the strobe.
 */
`timescale 1ns/1ps
module deac_cpu_model (
	input wire logic clk, // bus clock
	input wire deac_pkg::deac_rsp_t busRsp, // controller answer
	output deac_pkg::deac_req_t busReq, // request to controller
	output logic fetch // fetch marker
);
	////////////////////////////////////////////////////////////////////////////////
	// idle bus at time zero
	initial begin
		busReq = '{16'h0000, 8'h00, 1'b0, 1'b0};
		fetch = 1'b0;
	end

	// released address and data are inverted so stale values never match
	task automatic write(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		busReq <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		busReq <= '{~a, ~d, 1'b0, 1'b0};
	endtask

	// data sampled in the single cycle after the strobe
	task automatic read(input logic [15:0] a, input logic f, output logic [7:0] d,
		output logic drv);
		@(posedge clk);
		busReq <= '{a, ~busReq.wdata, 1'b0, 1'b1};
		fetch <= f;
		@(posedge clk);
		busReq <= '{~a, busReq.wdata, 1'b0, 1'b0};
		fetch <= 1'b0;
		#1;
		d = busRsp.rdata;
		drv = busRsp.drive;
	endtask
endmodule

// file: tb/test_data_eeprom_access_ctrl.sv
/*
 * Self-checking bench for the data eeprom access controller.
 * Assumes the cpu model drives the bus; options driven here as levels.
 */
`timescale 1ns/1ps
module test_data_eeprom_access_ctrl;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic appProg = 1'b0, readoutProtect = 1'b0, writeProtect = 1'b0, extAccess = 1'b0;
	logic waitReq = 1'b0, haltReq = 1'b0, unprotectReq = 1'b0;
	deac_pkg::deac_req_t busReq;
	deac_pkg::deac_rsp_t busRsp;
	logic fetch, eeWaitState, flashWriteOk, flashErase, drv;
	logic [7:0] rdat;
	int err_total = 0;
	int total_checks = 0;
	int n;
	localparam logic [15:0] CA = deac_pkg::EE_CTRL_ADDR;

	////////////////////////////////////////////////////////////////////////////////
	// 4 ns clock
	always #2 clk = ~clk;

	deac_cpu_model cpu (.clk(clk), .busRsp(busRsp), .busReq(busReq), .fetch(fetch));
	deac_top uut (.clk(clk), .rst_b(rst_b), .busReq(busReq), .fetch(fetch),
		.appProg(appProg), .readoutProtect(readoutProtect), .writeProtect(writeProtect),
		.extAccess(extAccess), .waitReq(waitReq), .haltReq(haltReq),
		.unprotectReq(unprotectReq), .busRsp(busRsp), .eeWaitState(eeWaitState),
		.flashWriteOk(flashWriteOk), .flashErase(flashErase));

	////////////////////////////////////////////////////////////////////////////////
	// comparison, verdict and helpers
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic rd(input logic [15:0] a);
		cpu.read(a, 1'b0, rdat, drv);
	endtask

	// poll the go bit; each poll costs two cycles, bounded
	task automatic go_wait;
		n = 0;
		rdat = 8'h01;
		while (rdat[0] !== 1'b0 && n < 4000) begin
			rd(CA);
			n += 2;
		end
	endtask

	// load one latch byte then start the cycle
	task automatic arm(input logic [15:0] a, input logic [7:0] d);
		cpu.write(CA, 8'h02);
		cpu.write(a, d);
		cpu.write(CA, 8'h03);
	endtask

	// hang guard, far beyond the expected run
	initial begin
		#200000;
		err_total++;
		final_report();
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		// this bench is the only reset source; no far-side pin moves meanwhile
		rst_b <= 1'b1;
		rd(CA); check(rdat, 8'h00);
		cpu.write(CA, 8'h02);
		rd(CA); check(rdat, 8'h02);
		rd(16'h1023); check({7'h00, drv}, 8'h00);
		cpu.write(16'h1023, 8'hf7);
		cpu.write(16'h1023, 8'h5e);
		cpu.write(16'h1024, 8'h33);
		cpu.write(CA, 8'h03);
		rd(CA); check(rdat, 8'h03);
		go_wait();
		check(rdat, 8'h00);
		check({7'h00, n >= deac_pkg::PROG_CYCLES}, 8'h01);
		check({7'h00, n <= deac_pkg::PROG_CYCLES + 12}, 8'h01);
		rd(16'h1023); check(rdat, 8'h56);
		check({7'h00, drv}, 8'h01);
		rd(16'h1024); check(rdat, 8'h33);
		// write with latch mode clear must not land
		cpu.write(16'h1023, 8'h00);
		rd(16'h1023); check(rdat, 8'h56);
		// latch falling edge discards the pending byte at 0x1024
		cpu.write(CA, 8'h02);
		cpu.write(16'h1024, 8'h00);
		cpu.write(CA, 8'h00);
		arm(16'h1023, 8'h56);
		go_wait();
		rd(16'h1024); check(rdat, 8'h33);
		cpu.read(16'h1023, 1'b1, rdat, drv); check({7'h00, drv}, 8'h00);
		@(posedge clk);
		readoutProtect <= 1'b1;
		extAccess <= 1'b1;
		rd(16'h1023); check({7'h00, drv}, 8'h00);
		// a protected rewrite must leave the byte untouched
		arm(16'h1023, 8'h00);
		go_wait();
		@(posedge clk);
		extAccess <= 1'b0;
		rd(16'h1023); check(rdat, 8'h56);
		@(posedge clk);
		readoutProtect <= 1'b0;
		// wait request during a cycle is deferred until it ends
		arm(16'h1023, 8'h56);
		waitReq <= 1'b1;
		repeat (4) @(posedge clk);
		#1 check({7'h00, eeWaitState}, 8'h00);
		go_wait();
		repeat (2) @(posedge clk);
		#1 check({7'h00, eeWaitState}, 8'h01);
		@(posedge clk);
		waitReq <= 1'b0;
		// halt abandons the running cycle
		arm(16'h1023, 8'h56);
		haltReq <= 1'b1;
		repeat (3) @(posedge clk);
		haltReq <= 1'b0;
		rd(CA); check(rdat, 8'h00);
		cpu.write(deac_pkg::FLASH_CTRL_ADDR, 8'h07);
		rd(deac_pkg::FLASH_CTRL_ADDR); check(rdat, 8'h00);
		cpu.write(deac_pkg::FLASH_CTRL_ADDR, deac_pkg::KEY1);
		cpu.write(deac_pkg::FLASH_CTRL_ADDR, deac_pkg::KEY2);
		cpu.write(deac_pkg::FLASH_CTRL_ADDR, 8'h07);
		rd(deac_pkg::FLASH_CTRL_ADDR); check(rdat, 8'h07);
		@(posedge clk);
		appProg <= 1'b1;
		cpu.write(deac_pkg::FLASH_BASE, 8'h00);
		#1 check({7'h00, flashWriteOk}, 8'h01);
		cpu.write(deac_pkg::SECTOR0_BASE, 8'h00);
		#1 check({7'h00, flashWriteOk}, 8'h00);
		@(posedge clk);
		writeProtect <= 1'b1;
		cpu.write(deac_pkg::FLASH_BASE, 8'h00);
		#1 check({7'h00, flashWriteOk}, 8'h00);
		// flash write protect must not stop eeprom programming
		arm(16'h1023, 8'h12);
		go_wait();
		rd(16'h1023); check(rdat, 8'h12);
		@(posedge clk);
		unprotectReq <= 1'b1;
		@(posedge clk);
		unprotectReq <= 1'b0;
		#1 check({7'h00, flashErase}, 8'h01);
		// the wipe needs one clock per byte before the row reads erased
		repeat (260) @(posedge clk);
		rd(16'h1023); check(rdat, deac_pkg::ERASED);
		final_report();
	end
endmodule

// file: verilog/deac_pkg.sv
/*
 * Constants and types for the data eeprom access controller.
 * Assumes a single 250 MHz clock and a synchronous, active-low reset.
 */
// Summary of operation
// - latch mode clear, eeprom reads return array byte
// - eeprom range is data only, no fetch
// - latch-mode writes captured in 32 latches
// - go bit programs latched bytes to row
// - end of cycle clears go and latch
// - latches cleared at end/fall; writes AND
// - latches cannot be read back
// - aborted cycle leaves cells undefined; here the cells keep their old data
// - wait request waits for cycle end
// - halt stops at once, abandoning cycle
// - eeprom reads in latch mode leave bus undriven
// - writes with latch mode clear ignored
// - readout protect blocks external access; erase
// - one protect bit covers both memories
// - write protect blocks flash, not eeprom
// - application programming refuses sector 0
// - program cycle timed internally
// - latch clear accepted only with go clear
// - control bits 7:2 zero, 1 latch, 0 go
package deac_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int ROW_BYTES = 32;
	localparam int COL_W = 5;
	localparam int ROWS = 8;
	localparam int ROW_W = 3;
	localparam logic [15:0] EE_BASE = 16'h1000;
	localparam logic [15:0] EE_LAST = 16'h10ff;
	localparam logic [15:0] FLASH_BASE = 16'he000;
	localparam logic [15:0] SECTOR0_BASE = 16'hfc00;
	localparam logic [15:0] EE_CTRL_ADDR = 16'h0030;
	localparam logic [15:0] FLASH_CTRL_ADDR = 16'h0031;
	localparam logic [15:0] OPTION_ADDR = 16'h0032;
	localparam int GO_BIT = 0;
	localparam int LATCH_BIT = 1;
	localparam int ROW_SELECT_BIT = 2; // option row select, unused by this block
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] KEY1 = 8'h56;
	localparam logic [7:0] KEY2 = 8'hae;
	localparam logic [7:0] ERASED = 8'hff;
	localparam int PROG_TIME_US = 3;
	localparam int CLK_MHZ = 250;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} deac_req_t;
	typedef struct packed {
		logic [7:0] rdata;
		logic drive;
	} deac_rsp_t;
endpackage

// file: verilog/deac_top.sv
/*
 * Data eeprom access controller: control register, 32-byte row latch,
 * self-timed programming, flash control unlock and protection gating.
 * Assumes the cpu bus is on clk; wait/halt/options are same-domain levels.
 */
`timescale 1ns/1ps
module deac_top (
	input wire logic clk, // 250 MHz
	input wire logic rst_b, // sync reset, low
	input wire deac_pkg::deac_req_t busReq, // cpu bus request
	input wire logic fetch, // request is an instruction fetch
	input wire logic appProg, // application programming mode
	input wire logic readoutProtect, // readout protect option
	input wire logic writeProtect, // flash write protect option
	input wire logic extAccess, // access from external tool
	input wire logic waitReq, // wait or active halt requested
	input wire logic haltReq, // halt requested
	input wire logic unprotectReq, // option reprogram removing protection
	output deac_pkg::deac_rsp_t busRsp, // read data, one cycle later
	output logic eeWaitState, // eeprom in wait state
	output logic flashWriteOk, // flash write allowed pulse
	output logic flashErase // full flash erase pulse
);
	logic latchMode;
	logic progGo;
	logic [7:0] latchData [deac_pkg::ROW_BYTES];
	logic [deac_pkg::ROW_BYTES-1:0] latchValid;
	logic [deac_pkg::ROW_W-1:0] rowAddr;
	// no reset on the array: contents stay undefined until programmed
	logic [7:0] array [deac_pkg::ROWS*deac_pkg::ROW_BYTES];
	logic [15:0] timer;
	logic [1:0] keyState;
	logic flashUnlocked;
	logic [7:0] flashCtrl;
	logic wipe;
	logic [8:0] wipeIdx;
	logic progDone;
	logic latchFall;
	logic inEe;
	logic ctrlWr;
	logic [deac_pkg::COL_W-1:0] col;
	logic eeWrOk;

	////////////////////////////////////////////////////////////////////////
	// decode
	assign inEe = busReq.addr >= deac_pkg::EE_BASE && busReq.addr <= deac_pkg::EE_LAST;
	assign col = busReq.addr[deac_pkg::COL_W-1:0];
	assign ctrlWr = busReq.wr && busReq.addr == deac_pkg::EE_CTRL_ADDR;
	assign progDone = progGo && timer == 16'(deac_pkg::PROG_CYCLES - 1);
	// a software clear is honoured only while idle
	assign latchFall = latchMode && ((ctrlWr && !busReq.wdata[deac_pkg::LATCH_BIT] && !progGo)
		|| progDone);
	// eeprom writes land only in latch mode, idle, and never from a protected tool
	assign eeWrOk = busReq.wr && inEe && latchMode && !progGo
		&& !(readoutProtect && extAccess);

	////////////////////////////////////////////////////////////////////////
	// control register: latch mode and go bit
	always_ff @(posedge clk) begin
		if (!rst_b || haltReq) begin
			latchMode <= 1'b0;
			progGo <= 1'b0;
		end else if (progDone) begin
			latchMode <= 1'b0;
			progGo <= 1'b0;
		end else if (ctrlWr) begin
			if (busReq.wdata[deac_pkg::LATCH_BIT])
				latchMode <= 1'b1;
			else if (!progGo)
				latchMode <= 1'b0;
			// go only starts from latch mode; a clear aborts the cycle
			if (busReq.wdata[deac_pkg::GO_BIT] && latchMode && !waitReq)
				progGo <= 1'b1;
			else if (!busReq.wdata[deac_pkg::GO_BIT])
				progGo <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// internal programming timer, no software timing needed
	// a halt or an abort drops go, which rewinds the timer
	always_ff @(posedge clk) begin
		if (!rst_b || !progGo || progDone)
			timer <= 16'h0000;
		else
			timer <= timer + 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////
	// row latch: repeated writes AND together
	genvar gi;
	generate
		for (gi = 0; gi < deac_pkg::ROW_BYTES; gi++) begin : g_latch
			always_ff @(posedge clk) begin
				if (!rst_b || latchFall || haltReq) begin
					latchValid[gi] <= 1'b0;
					latchData[gi] <= deac_pkg::ERASED;
				end else if (eeWrOk && col == 5'(gi)) begin
					latchValid[gi] <= 1'b1;
					latchData[gi] <= latchData[gi] & busReq.wdata;
				end
			end
		end
	endgenerate

	// row follows the last latch write; writes with latch clear are dropped
	always_ff @(posedge clk) begin
		if (!rst_b)
			rowAddr <= '0;
		else if (eeWrOk)
			rowAddr <= busReq.addr[deac_pkg::COL_W +: deac_pkg::ROW_W];
	end

	////////////////////////////////////////////////////////////////////////
	// array: programmed at cycle end, wiped when protection is removed
	// the wipe takes one byte per clock; reads during it may still see old data
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wipe <= 1'b0;
			wipeIdx <= 9'h000;
		end else if (unprotectReq && !wipe) begin
			wipe <= 1'b1;
			wipeIdx <= 9'h000;
		end else if (wipe) begin
			wipeIdx <= wipeIdx + 9'h001;
			if (wipeIdx == 9'h0ff)
				wipe <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (wipe)
			array[wipeIdx[7:0]] <= deac_pkg::ERASED;
		else if (progDone) begin
			for (int i = 0; i < deac_pkg::ROW_BYTES; i++)
				if (latchValid[i])
					array[{rowAddr, 5'(i)}] <= latchData[i];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flash control unlock: 56h then aeh before writes take effect
	// a wrong key restarts the sequence; unlock then holds until reset
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			keyState <= 2'h0;
			flashUnlocked <= 1'b0;
			flashCtrl <= deac_pkg::CTRL_RESET;
		end else if (busReq.wr && busReq.addr == deac_pkg::FLASH_CTRL_ADDR) begin
			if (flashUnlocked)
				flashCtrl <= {5'h00, busReq.wdata[2:0]};
			else if (keyState == 2'h0 && busReq.wdata == deac_pkg::KEY1)
				keyState <= 2'h1;
			else if (keyState == 2'h1 && busReq.wdata == deac_pkg::KEY2)
				flashUnlocked <= 1'b1;
			else
				keyState <= 2'h0;
		end
	end

	// flash writes: blocked by write protect and by sector 0 under application programming
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			flashWriteOk <= 1'b0;
			flashErase <= 1'b0;
		end else begin
			flashWriteOk <= busReq.wr && busReq.addr >= deac_pkg::FLASH_BASE
				&& flashUnlocked && !writeProtect
				&& !(appProg && busReq.addr >= deac_pkg::SECTOR0_BASE)
				&& !(readoutProtect && extAccess);
			flashErase <= unprotectReq && !wipe;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// wait state: a wait request enters once any cycle has finished; a halt enters at once
	always_ff @(posedge clk) begin
		if (!rst_b)
			eeWaitState <= 1'b0;
		else
			eeWaitState <= (waitReq && !progGo) || haltReq;
	end

	////////////////////////////////////////////////////////////////////////
	// read port, answer in the next cycle; latch contents never readable
	always_ff @(posedge clk) begin
		if (!rst_b)
			busRsp <= '0;
		else begin
			busRsp <= '0;
			if (busReq.rd && busReq.addr == deac_pkg::EE_CTRL_ADDR)
				busRsp <= '{rdata: {6'h00, latchMode, progGo}, drive: 1'b1};
			else if (busReq.rd && busReq.addr == deac_pkg::FLASH_CTRL_ADDR)
				busRsp <= '{rdata: flashCtrl, drive: 1'b1};
			else if (busReq.rd && inEe && !fetch && !latchMode
				&& !(readoutProtect && extAccess))
				busRsp <= '{rdata: array[busReq.addr[7:0]], drive: 1'b1};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_done_clears;
		@(posedge clk) disable iff (!rst_b) progDone && !haltReq |=> !progGo && !latchMode;
	endproperty
	a_done_clears: assert property (p_done_clears) else $error("cycle end left bits set");
	property p_timed;
		@(posedge clk) disable iff (!rst_b) $rose(progGo) |-> timer == 16'h0000;
	endproperty
	a_timed: assert property (p_timed) else $error("timer not restarted");
	property p_latch_rd;
		@(posedge clk) disable iff (!rst_b) busReq.rd && inEe && latchMode |=> !busRsp.drive;
	endproperty
	a_latch_rd: assert property (p_latch_rd) else $error("latch mode read drove bus");
	property p_no_write;
		@(posedge clk) disable iff (!rst_b) busReq.wr && inEe && !latchMode |=> $stable(latchValid);
	endproperty
	a_no_write: assert property (p_no_write) else $error("write latched in read mode");
	property p_lat_hold;
		@(posedge clk) disable iff (!rst_b) progGo && !progDone && !haltReq |=> latchMode;
	endproperty
	a_lat_hold: assert property (p_lat_hold) else $error("latch cleared while busy");
	property p_rd_data;
		@(posedge clk) disable iff (!rst_b) busReq.rd && busReq.addr == deac_pkg::EE_CTRL_ADDR
			|=> busRsp.drive && busRsp.rdata[7:2] == 6'h00;
	endproperty
	a_rd_data: assert property (p_rd_data) else $error("control read wrong");
	property p_halt;
		@(posedge clk) disable iff (!rst_b) haltReq |=> !progGo;
	endproperty
	a_halt: assert property (p_halt) else $error("halt did not stop");
	property p_fetch;
		@(posedge clk) disable iff (!rst_b) busReq.rd && inEe && fetch |=> !busRsp.drive;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch served");
	property p_sect0;
		@(posedge clk) disable iff (!rst_b) appProg && busReq.addr >= deac_pkg::SECTOR0_BASE
			|=> !flashWriteOk;
	endproperty
	a_sect0: assert property (p_sect0) else $error("sector 0 write allowed");
	property p_wait;
		@(posedge clk) disable iff (!rst_b) waitReq && progGo |=> !eeWaitState || $past(haltReq);
	endproperty
	a_wait: assert property (p_wait) else $error("wait during cycle");

	// external writes under readout protection never reach the latches
	property p_ro_write;
		@(posedge clk) disable iff (!rst_b) busReq.wr && inEe && readoutProtect && extAccess
			&& !latchFall && !haltReq |=> $stable(latchValid);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("protected write latched");

	// external reads under readout protection leave the bus undriven
	property p_ro_read;
		@(posedge clk) disable iff (!rst_b) busReq.rd && inEe && readoutProtect && extAccess
			|=> !busRsp.drive;
	endproperty
	a_ro_read: assert property (p_ro_read) else $error("protected read served");

	// write protect keeps every flash write out
	property p_wp_flash;
		@(posedge clk) disable iff (!rst_b) writeProtect |=> !flashWriteOk;
	endproperty
	a_wp_flash: assert property (p_wp_flash) else $error("protected flash write allowed");

	// no flash write passes before both keys
	property p_locked;
		@(posedge clk) disable iff (!rst_b) !flashUnlocked |=> !flashWriteOk;
	endproperty
	a_locked: assert property (p_locked) else $error("flash write before unlock");

	// timer never runs past the programming length
	property p_timer_bound;
		@(posedge clk) disable iff (!rst_b) progGo |-> timer < 16'(deac_pkg::PROG_CYCLES);
	endproperty
	a_timer_bound: assert property (p_timer_bound) else $error("timer overran");

	// an idle wait request enters the wait state on the next edge
	property p_wait_idle;
		@(posedge clk) disable iff (!rst_b) waitReq && !progGo |=> eeWaitState;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("idle wait not entered");

	// go is refused while a wait request stands
	property p_wait_go;
		@(posedge clk) disable iff (!rst_b) waitReq && !progGo |=> !progGo;
	endproperty
	a_wait_go: assert property (p_wait_go) else $error("cycle started in wait");

	// go needs latch mode already set
	property p_go_needs_latch;
		@(posedge clk) disable iff (!rst_b) !latchMode |=> !progGo;
	endproperty
	a_go_needs_latch: assert property (p_go_needs_latch) else $error("go without latch");

	// clearing go mid-cycle aborts it
	property p_abort;
		@(posedge clk) disable iff (!rst_b) ctrlWr && !busReq.wdata[deac_pkg::GO_BIT] |=> !progGo;
	endproperty
	a_abort: assert property (p_abort) else $error("go clear ignored");

	// latches are empty after a falling latch bit or a halt
	property p_lat_empty;
		@(posedge clk) disable iff (!rst_b) latchFall || haltReq |=> latchValid == '0;
	endproperty
	a_lat_empty: assert property (p_lat_empty) else $error("latches not cleared");

	// halt drops latch mode as well
	property p_halt_lat;
		@(posedge clk) disable iff (!rst_b) haltReq |=> !latchMode;
	endproperty
	a_halt_lat: assert property (p_halt_lat) else $error("halt kept latch mode");

	// control read returns the bits as they stood at the strobe
	property p_ctrl_val;
		@(posedge clk) disable iff (!rst_b) busReq.rd && busReq.addr == deac_pkg::EE_CTRL_ADDR
			|=> busRsp.rdata[1:0] == {$past(latchMode), $past(progGo)};
	endproperty
	a_ctrl_val: assert property (p_ctrl_val) else $error("control bits wrong");

	// read data stand only in the cycle after a strobe
	property p_rsp_idle;
		@(posedge clk) disable iff (!rst_b) !busReq.rd |=> !busRsp.drive;
	endproperty
	a_rsp_idle: assert property (p_rsp_idle) else $error("bus driven without read");

	// removing protection pulses the full erase and starts the wipe
	property p_erase;
		@(posedge clk) disable iff (!rst_b) unprotectReq && !wipe |=> flashErase && wipe;
	endproperty
	a_erase: assert property (p_erase) else $error("erase not started");

	// unprotected eeprom data reads with latch clear are served in the next cycle
	property p_ee_read;
		@(posedge clk) disable iff (!rst_b) busReq.rd && inEe && !latchMode && !fetch
			&& !(readoutProtect && extAccess) |=> busRsp.drive;
	endproperty
	a_ee_read: assert property (p_ee_read) else $error("eeprom read not served");

	c_prog: cover property (@(posedge clk) disable iff (!rst_b) progDone);
	c_and: cover property (@(posedge clk) disable iff (!rst_b)
		busReq.wr && inEe && latchMode && latchValid[col]);
	c_unlock: cover property (@(posedge clk) disable iff (!rst_b) $rose(flashUnlocked));
	// a finished wipe and an entered wait state
	c_wipe: cover property (@(posedge clk) disable iff (!rst_b) $fell(wipe));
	c_wait: cover property (@(posedge clk) disable iff (!rst_b) $rose(eeWaitState) && !haltReq);
endmodule
